// ### rtl/scdd_consts.svh
// Constants for the sample-clock delay and clock-detect register bank.
// Assumes inclusion by bare name from the register module.
`ifndef SCDD_CONSTS_SVH
`define SCDD_CONSTS_SVH
`define SCDD_OFS_LOCAL_FINE 12'h112
`define SCDD_OFS_DIG_SUPER 12'h113
`define SCDD_OFS_DIG_FINE 12'h114
`define SCDD_OFS_DET_CTRL 12'h11A
`define SCDD_OFS_DET_STAT 12'h11B
`define SCDD_RST_FINE 8'hC0
`define SCDD_RST_SUPER 8'h00
`define SCDD_RST_THRESH 2'h1
`define SCDD_RST_DET_RSVD 3'h6
`define SCDD_RST_DET_HI 3'h0
`define SCDD_THRESH_HI 4
`define SCDD_THRESH_LO 3
`define SCDD_MODE_NONE 3'h0
`define SCDD_MODE_FINE16 3'h2
`define SCDD_MODE_FINE16_LJ 3'h3
`define SCDD_MODE_FINE192 3'h4
`define SCDD_MODE_FINE_SUPER 3'h6
`define SCDD_FINE16_MAX 8'h10
`endif

// ### rtl/scdd_pkg.sv
// Types for the sample-clock delay and clock-detect register bank.
// Uses no constants; the header is included only by the register module.
package scdd_pkg;
  typedef enum logic [1:0] {
    SCDD_IDLE,
    SCDD_WRITE,
    SCDD_READ
  } scdd_op_t;

  typedef struct packed {
    logic [7:0] fine;
    logic [7:0] super_fine;
    logic fine_en;
    logic super_en;
  } scdd_delay_t;
endpackage

// ### rtl/scdd_regs.sv
// Register bank for the sample-clock fine and super-fine delays and clock detect.
// Assumes the configuration port's write and read strobes are already in SYS_CLK,
// and that the clock-detect input comes from another domain.
//
// Contract
// - Local fine delay held, used modes 2,3,4,6.
// - Digital super-fine delay used in modes 2,6.
// - Digital fine delay held, used modes 2,3,4,6.
// - Fine delays reset 0xC0, super-fine resets zero.
// - Threshold field bits 4:3, resets to 01.
// - Status bit 0 shows clock detected, resets 0.
// - Status upper bits zero; control 2:0 reset 6.
// - Three-bit mode selects none, fine16, fine16 LJ, fine192, super.
`timescale 1ns/1ps
`include "scdd_consts.svh"
module scdd_regs
  import scdd_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Configuration port.
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [11:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  // Clock path.
  input wire logic [2:0] DELAY_MODE,
  input wire logic CLK_DETECTED,
  output scdd_delay_t LOCAL_DELAY,
  output scdd_delay_t DIGITAL_DELAY,
  output logic [1:0] DETECT_THRESHOLD,
  output logic FINE_RANGE_WARN
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] local_fine_reg;
  logic [7:0] dig_super_reg;
  logic [7:0] dig_fine_reg;
  logic [7:0] det_ctrl_reg;
  logic det_sync1_reg;
  logic det_sync2_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  scdd_op_t op_reg;
  scdd_op_t op_next;

  wire sel_local = CFG_ADDR == `SCDD_OFS_LOCAL_FINE;
  wire sel_super = CFG_ADDR == `SCDD_OFS_DIG_SUPER;
  wire sel_dfine = CFG_ADDR == `SCDD_OFS_DIG_FINE;
  wire sel_ctrl = CFG_ADDR == `SCDD_OFS_DET_CTRL;
  wire sel_stat = CFG_ADDR == `SCDD_OFS_DET_STAT;
  // Modes 2,3,4,6 use fine delay; 2 and 6 use super-fine; 0 and others none.
  wire fine_used = (DELAY_MODE == `SCDD_MODE_FINE16) ||
    (DELAY_MODE == `SCDD_MODE_FINE16_LJ) || (DELAY_MODE == `SCDD_MODE_FINE192) ||
    (DELAY_MODE == `SCDD_MODE_FINE_SUPER);
  wire super_used = (DELAY_MODE == `SCDD_MODE_FINE16) ||
    (DELAY_MODE == `SCDD_MODE_FINE_SUPER);
  wire short_mode = (DELAY_MODE == `SCDD_MODE_FINE16) ||
    (DELAY_MODE == `SCDD_MODE_FINE16_LJ);

  // ****************************************
  // Writes
  // ****************************************
  // Out-of-range values are stored as written; a warning flags misuse instead.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      local_fine_reg <= `SCDD_RST_FINE;
      dig_fine_reg <= `SCDD_RST_FINE;
      dig_super_reg <= `SCDD_RST_SUPER;
      det_ctrl_reg <= {`SCDD_RST_DET_HI, `SCDD_RST_THRESH, `SCDD_RST_DET_RSVD};
    end else if (CFG_WR) begin
      if (sel_local) local_fine_reg <= CFG_WDATA;
      if (sel_super) dig_super_reg <= CFG_WDATA;
      if (sel_dfine) dig_fine_reg <= CFG_WDATA;
      if (sel_ctrl) det_ctrl_reg <= CFG_WDATA;
    end
  end

  // Detect input crosses domains through two flops.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      det_sync1_reg <= 1'b0;
      det_sync2_reg <= 1'b0;
    end else begin
      det_sync1_reg <= CLK_DETECTED;
      det_sync2_reg <= det_sync1_reg;
    end
  end

  // ****************************************
  // Reads
  // ****************************************
  always_comb begin
    op_next = CFG_WR ? SCDD_WRITE : (CFG_RD ? SCDD_READ : SCDD_IDLE);
    rdata_next = rdata_reg;
    if (CFG_RD) begin
      if (sel_local) rdata_next = local_fine_reg;
      else if (sel_super) rdata_next = dig_super_reg;
      else if (sel_dfine) rdata_next = dig_fine_reg;
      else if (sel_ctrl) rdata_next = det_ctrl_reg;
      else if (sel_stat) rdata_next = {7'h00, det_sync2_reg};
      else rdata_next = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
      op_reg <= SCDD_IDLE;
    end else begin
      rdata_reg <= rdata_next;
      op_reg <= op_next;
    end
  end

  // ****************************************
  // Clock path outputs
  // ****************************************
  // Stored values never change with mode; only the enables gate their use.
  assign LOCAL_DELAY = '{fine: local_fine_reg, super_fine: 8'h00,
    fine_en: fine_used, super_en: 1'b0};
  assign DIGITAL_DELAY = '{fine: dig_fine_reg, super_fine: dig_super_reg,
    fine_en: fine_used, super_en: super_used};
  assign DETECT_THRESHOLD = det_ctrl_reg[`SCDD_THRESH_HI:`SCDD_THRESH_LO];
  assign FINE_RANGE_WARN = short_mode &&
    ((local_fine_reg > `SCDD_FINE16_MAX) || (dig_fine_reg > `SCDD_FINE16_MAX));
  assign CFG_RDATA = rdata_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_fine_reset: assert property (@(posedge SYS_CLK) !RST_N |=>
    local_fine_reg == 8'hC0 && dig_fine_reg == 8'hC0 && dig_super_reg == 8'h00)
    else $error("Delay reset values wrong.");
  chk_local_fine_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_WR && sel_local |=> LOCAL_DELAY.fine == $past(CFG_WDATA))
    else $error("Local fine write lost.");
  chk_super_enable: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    DIGITAL_DELAY.super_en == (DELAY_MODE == 3'h2 || DELAY_MODE == 3'h6))
    else $error("Super-fine enable wrong.");
  chk_dig_fine_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_RD && !CFG_WR && sel_dfine |=> CFG_RDATA == $past(dig_fine_reg))
    else $error("Digital fine readback wrong.");
  chk_thresh_reset: assert property (@(posedge SYS_CLK) !RST_N |=>
    DETECT_THRESHOLD == 2'h1 && det_ctrl_reg[2:0] == 3'h6)
    else $error("Detect control reset wrong.");
  chk_status_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_DETECTED [*3] |-> ##1 det_sync2_reg)
    else $error("Detect status not following input.");
  chk_status_upper: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_RD && sel_stat |=> CFG_RDATA[7:1] == 7'h00)
    else $error("Status upper bits not zero.");
  chk_fine_mode: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    DELAY_MODE == 3'h0 |-> !LOCAL_DELAY.fine_en && !DIGITAL_DELAY.fine_en)
    else $error("Fine delay used in mode zero.");
  chk_keep_value: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !CFG_WR |=> $stable(dig_super_reg) && $stable(local_fine_reg))
    else $error("Delay value changed without a write.");

  // ****************************************
  // Checks on the write path
  // ****************************************
  // A write strobe must land in its register on the very next edge.
  chk_write_wins: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    op_reg == SCDD_WRITE && $past(sel_dfine) |-> DIGITAL_DELAY.fine == $past(CFG_WDATA))
    else $error("Digital fine write lost.");
  chk_super_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_WR && sel_super |=> DIGITAL_DELAY.super_fine == $past(CFG_WDATA))
    else $error("Super-fine write lost.");
  chk_thresh_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_WR && sel_ctrl |=>
    DETECT_THRESHOLD == $past(CFG_WDATA[`SCDD_THRESH_HI:`SCDD_THRESH_LO]))
    else $error("Detect threshold write lost.");
  chk_ctrl_keep: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !CFG_WR |=> $stable(dig_fine_reg) && $stable(det_ctrl_reg))
    else $error("Control value changed without a write.");

  // ****************************************
  // Checks on the read and status path
  // ****************************************
  // The status bit is two edges late; a faster path would risk a metastable read.
  chk_status_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_RD && !CFG_WR && sel_stat |=> CFG_RDATA[0] == $past(det_sync2_reg))
    else $error("Status bit readback wrong.");
  chk_status_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !CLK_DETECTED [*3] |-> !det_sync2_reg)
    else $error("Detect status not clearing.");
  chk_ctrl_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CFG_RD && !CFG_WR && sel_ctrl |=> CFG_RDATA == $past(det_ctrl_reg))
    else $error("Control readback wrong.");

  // ****************************************
  // Checks on the clock path
  // ****************************************
  // Enables follow the mode at once, so a mode change needs no register write.
  chk_fine_enable: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    LOCAL_DELAY.fine_en == (DELAY_MODE inside {3'h2, 3'h3, 3'h4, 3'h6}))
    else $error("Local fine enable wrong.");
  chk_dig_fine_enable: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    DIGITAL_DELAY.fine_en == (DELAY_MODE inside {3'h2, 3'h3, 3'h4, 3'h6}))
    else $error("Digital fine enable wrong.");
  chk_local_super_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !LOCAL_DELAY.super_en && LOCAL_DELAY.super_fine == 8'h00)
    else $error("Local super-fine path not idle.");
  chk_range_warn: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    FINE_RANGE_WARN == ((DELAY_MODE == 3'h2 || DELAY_MODE == 3'h3) &&
    (LOCAL_DELAY.fine > 8'h10 || DIGITAL_DELAY.fine > 8'h10)))
    else $error("Fine range warning wrong.");

  // ****************************************
  // Coverage
  // ****************************************
  // Mode 6 with a write shows that reprogramming a live delay path is reachable.
  cov_mode_super: cover property (@(posedge SYS_CLK) DELAY_MODE == 3'h6 && CFG_WR);
  cov_detect_rise: cover property (@(posedge SYS_CLK) $rose(det_sync2_reg));
  cov_range_warn: cover property (@(posedge SYS_CLK) FINE_RANGE_WARN);
  cov_status_read: cover property (@(posedge SYS_CLK) CFG_RD && sel_stat && det_sync2_reg);
endmodule

// ### tb/scdd_regs_tb.sv
// Self-checking bench for the sample-clock delay and clock-detect register bank.
// Assumes the register module and package are compiled first; the bench drives every port.
`timescale 1ns/1ps
module scdd_regs_tb;
  import scdd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [7:0] cfg_wdata = 8'h00;
  logic [2:0] delay_mode = 3'h0;
  logic clk_detected = 1'b0;
  logic [7:0] cfg_rdata;
  scdd_delay_t local_delay;
  scdd_delay_t digital_delay;
  logic [1:0] detect_threshold;
  logic fine_range_warn;
  int fails = 0;
  int n_tests = 0;
  always #50 sys_clk = ~sys_clk;
  scdd_regs i_scdd_regs (.SYS_CLK(sys_clk), .RST_N(rst_n), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
    .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
    .DELAY_MODE(delay_mode), .CLK_DETECTED(clk_detected), .LOCAL_DELAY(local_delay),
    .DIGITAL_DELAY(digital_delay), .DETECT_THRESHOLD(detect_threshold),
    .FINE_RANGE_WARN(fine_range_warn));
  // ****************************************
  // Bus tasks and compare.
  // ****************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1;
    chk(cfg_rdata, e);
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_reset;
    rd(12'h112, 8'hC0);
    rd(12'h113, 8'h00);
    rd(12'h114, 8'hC0);
    rd(12'h11A, 8'h0E);
    rd(12'h11B, 8'h00);
    chk({6'h00, detect_threshold}, 8'h01);
  endtask
  task automatic t_write;
    wr(12'h113, 8'h80);
    chk(digital_delay.super_fine, 8'h80);
    wr(12'h114, 8'h05);
    chk(digital_delay.fine, 8'h05);
    wr(12'h11A, 8'h18);
    chk({6'h00, detect_threshold}, 8'h03);
    rd(12'h11A, 8'h18);
    wr(12'h11B, 8'hFF);
    rd(12'h11B, 8'h00);
    rd(12'h115, 8'h00);
  endtask
  // A fine value of 17 is legal only in the wide modes, so the warning marks modes 2 and 3.
  task automatic t_modes;
    logic fe;
    logic se;
    wr(12'h112, 8'h11);
    rd(12'h112, 8'h11);
    for (int m = 0; m < 8; m++) begin
      @(posedge sys_clk);
      delay_mode <= 3'(m);
      #1;
      fe = (m == 2) || (m == 3) || (m == 4) || (m == 6);
      se = (m == 2) || (m == 6);
      chk({6'h00, local_delay.fine_en, local_delay.super_en}, {6'h00, fe, 1'b0});
      chk({6'h00, digital_delay.fine_en, digital_delay.super_en}, {6'h00, fe, se});
      chk({7'h00, fine_range_warn}, {7'h00, m == 2 || m == 3});
      chk(local_delay.fine, 8'h11);
      chk(local_delay.super_fine, 8'h00);
    end
    wr(12'h112, 8'h10);
    wr(12'h114, 8'h11);
    @(posedge sys_clk);
    delay_mode <= 3'h3;
    #1;
    chk({7'h00, fine_range_warn}, 8'h01);
    wr(12'h114, 8'h10);
    chk({7'h00, fine_range_warn}, 8'h00);
  endtask
  task automatic t_status;
    @(posedge sys_clk);
    clk_detected <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(12'h11B, 8'h01);
    @(posedge sys_clk);
    clk_detected <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(12'h11B, 8'h00);
  endtask
  // A second reset after every register was written proves that reset reloads them.
  task automatic t_mid_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
  endtask
  task automatic report_and_stop;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_write();
    t_modes();
    t_status();
    t_mid_reset();
    report_and_stop();
  end
  // The tests need about 75 cycles; the limit is far beyond that so only a hang trips it.
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
